// File: hw/ssp_pkg.sv
// Constants, field layout and carrier types for the SPI serial port.
// Assumes one clk domain at 20 MHz; pins are synchronised before use.
//
// What this block does
// - Each transfer shifts one 8-bit word out and one in together.
// - All four clock polarity and transmit edge combinations work.
// - Data out, data in and serial clock; select only as slave.
// - Slave select input can qualify slave transfers.
// - Complete received word moves to buffer unless overrun; port flag is raised either way.
// - Buffer write loads buffer and shift register together.
// - Shift register has no software access except via buffer.
// - Status low six bits read-only, upper two bits read/write.
// - First control register is fully read/write.
// - Master sample-phase bit: set samples late, clear mid-bit.
// - Clock-edge bit: set sends on active-to-idle, else idle-to-active.
// - Idle and active levels come from clock idle polarity bit.
// - Stop status bit is clear when disabled; no SPI function.
// - Buffer-full reads 1 after a received word, 0 when empty.
// - Clearing enable need not restore full reset state.
// - Every instance runs independently with own registers and pins.
// - Mode field: master /4, /16, /64, timer/2; slave with/without select.
// - Clock idle polarity set means idle high, clear idle low.
// - Shift register moves data most significant bit first.
// - Buffer write during transfer is ignored and sets collision flag.

package ssp_pkg;

    // ========================================================
    // Register map (byte addresses)
    localparam logic [7:0] ADR_BUF = 8'h00;
    localparam logic [7:0] ADR_STAT = 8'h04;
    localparam logic [7:0] ADR_CTRL1 = 8'h08;

    // ========================================================
    // Field positions
    localparam int ST_SMP = 7;
    localparam int ST_CKE = 6;
    localparam int ST_BF = 0;
    localparam int C1_WRITE_COLLISION_FLAG = 7;
    localparam int C1_OVF = 6;
    localparam int C1_EN = 5;
    localparam int C1_CKP = 4;

    // ========================================================
    // Reset values
    localparam logic [7:0] STAT_RST = 8'h00;
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [3:0] MODE_RST = 4'h0;

    // ========================================================
    // Mode field encodings
    localparam logic [3:0] MODE_M4 = 4'h0;
    localparam logic [3:0] MODE_M16 = 4'h1;
    localparam logic [3:0] MODE_M64 = 4'h2;
    localparam logic [3:0] MODE_MTMR = 4'h3;
    localparam logic [3:0] MODE_SSEL = 4'h4;
    localparam logic [3:0] MODE_SFREE = 4'h5;

    // ========================================================
    // Timing: clk cycles per serial clock half period
    localparam logic [5:0] HALF_DIV4 = 6'h02;
    localparam logic [5:0] HALF_DIV16 = 6'h08;
    localparam logic [5:0] HALF_DIV64 = 6'h20;
    // Half-period ticks per word: 16 edges, plus a trailing half bit when cke is clear
    localparam logic [4:0] EDGE_LAST = 5'h10;
    localparam logic [4:0] TICK_LAST_CKE1 = 5'h10;
    localparam logic [4:0] TICK_LAST_CKE0 = 5'h11;
    localparam logic [4:0] SHIFT_FIRST_CKE0 = 5'h03;
    localparam logic [4:0] SHIFT_LAST_CKE0 = 5'h0f;
    localparam logic [4:0] SHIFT_LAST_CKE1 = 5'h0e;
    localparam logic [2:0] SLV_LAST_BIT = 3'h7;
    localparam int WORD_BITS = 8;

    // ========================================================
    // Carrier types
    typedef struct packed {
        logic sck;
        logic sdi;
        logic ss_n;
    } ssp_pins_s;

    typedef enum logic [0:0] {MST_IDLE, MST_RUN} ssp_mst_e;

endpackage

// File: hw/ssp_sync2.sv
// Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes the caller reads only q; stage one feeds stage two alone.
`timescale 1ns/1ps

module ssp_sync2 #(
    parameter int W = 3
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta;

    // ========================================================
    // One two-stage chain per bit
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk) begin
            if (srst) begin
                meta[i] <= 1'b0;
                q[i] <= 1'b0;
            end else if (ce) begin
                meta[i] <= d[i];
                q[i] <= meta[i];
            end
        end
    end

endmodule

// File: hw/ssp_spi_port.sv
// SPI mode of the synchronous serial port with a Wishbone register slave.
// Assumes a classic Wishbone master on clk and pins from another domain.
`timescale 1ns/1ps

module ssp_spi_port #(
    parameter int WORD_BITS = ssp_pkg::WORD_BITS
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic timer_tick,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe,
    output logic sdo_o,
    output logic sdo_oe,
    input wire logic sdi_i,
    input wire logic ss_n_i,
    output logic port_irq_flag
);

    // Word length is fixed by the edge schedule below
    if (WORD_BITS != 8) begin : g_bad_width
        $error("ssp_spi_port supports only 8-bit words");
    end

    // ========================================================
    // State
    logic input_sample_late, cke, bf;
    logic write_collision_flag, ovf, en, clock_idle_polarity;
    logic [3:0] mode;
    logic [7:0] xbuf, shreg;
    logic rx_bit;
    ssp_pkg::ssp_mst_e mst_state;
    logic [4:0] tick;
    logic [5:0] hcnt;
    logic sck_act, sck_q;
    logic [2:0] slv_cnt;
    ssp_pkg::ssp_pins_s pin_raw, pin_s;

    // ========================================================
    // Decode and datapath terms
    logic bus_req, wr_buf, rd_buf, wr_stat, wr_ctrl;
    logic is_master, is_slave, selected, s_active, run, abort, busy;
    logic buf_load, write_collision_flag_now, ovf_now;
    logic [5:0] half_len;
    logic half_tick, m_step;
    logic [4:0] ntick;
    logic shift_t, mid_t, end_t, samp_t, last_t;
    logic s_edge, s_leave, s_samp, s_shift;
    logic samp_now, shift_now, done_now, samp_val;
    logic [7:0] rx_word, stat_rd, ctrl_rd;
    logic [31:0] rd_mux;

    assign pin_raw = {sck_i, sdi_i, ss_n_i};

    ssp_sync2 #(.W(3)) u_sync (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .d(pin_raw),
        .q(pin_s)
    );

    // Bus strobes; a request is served once, in the cycle before ack
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_buf = bus_req && wb_we_i && wb_sel_i[0]
        && (wb_adr_i == ssp_pkg::ADR_BUF);
    assign rd_buf = bus_req && !wb_we_i && (wb_adr_i == ssp_pkg::ADR_BUF);
    assign wr_stat = bus_req && wb_we_i && wb_sel_i[0]
        && (wb_adr_i == ssp_pkg::ADR_STAT);
    assign wr_ctrl = bus_req && wb_we_i && wb_sel_i[0]
        && (wb_adr_i == ssp_pkg::ADR_CTRL1);

    // Mode decode; reserved codes leave the engine idle
    assign is_master = (mode[3:2] == 2'b00);
    assign is_slave = (mode == ssp_pkg::MODE_SSEL)
        || (mode == ssp_pkg::MODE_SFREE);
    assign selected = (mode == ssp_pkg::MODE_SFREE) || !pin_s.ss_n;
    assign s_active = en && is_slave && selected;
    assign run = (mst_state == ssp_pkg::MST_RUN);
    assign abort = run && (!en || !is_master);
    assign busy = run || (slv_cnt != 3'h0);

    // Collision: the write is dropped, only the flag records it
    assign write_collision_flag_now = wr_buf && busy;
    assign buf_load = wr_buf && !busy;

    // Master bit rate
    assign half_len = (mode == ssp_pkg::MODE_M4) ? ssp_pkg::HALF_DIV4
        : (mode == ssp_pkg::MODE_M16) ? ssp_pkg::HALF_DIV16
        : ssp_pkg::HALF_DIV64;
    assign half_tick = (mode == ssp_pkg::MODE_MTMR) ? timer_tick
        : (hcnt == half_len - 6'h01);
    assign m_step = run && !abort && half_tick;
    assign ntick = tick + 5'h01;

    // Edge schedule; with cke set bit 7 is out before the first edge
    assign shift_t = cke
        ? (!ntick[0] && ntick <= ssp_pkg::SHIFT_LAST_CKE1)
        : (ntick[0] && ntick >= ssp_pkg::SHIFT_FIRST_CKE0
           && ntick <= ssp_pkg::SHIFT_LAST_CKE0);
    assign mid_t = cke ? ntick[0] : !ntick[0];
    assign end_t = cke ? !ntick[0]
        : (ntick[0] && ntick >= ssp_pkg::SHIFT_FIRST_CKE0);
    assign samp_t = input_sample_late ? end_t : mid_t;
    assign last_t = (ntick == (cke ? ssp_pkg::TICK_LAST_CKE1
        : ssp_pkg::TICK_LAST_CKE0));

    // Slave edges; sample phase is assumed clear here
    assign s_edge = pin_s.sck != sck_q;
    assign s_leave = s_edge && (pin_s.sck != clock_idle_polarity);
    assign s_samp = s_active && (cke ? s_leave : (s_edge && !s_leave));
    assign s_shift = s_active && s_edge && !s_samp
        && (slv_cnt != 3'h0);

    // Merged master and slave steps
    assign samp_now = (m_step && samp_t) || s_samp;
    assign shift_now = (m_step && shift_t) || s_shift;
    assign done_now = (m_step && last_t)
        || (s_samp && slv_cnt == ssp_pkg::SLV_LAST_BIT);
    assign samp_val = samp_now ? pin_s.sdi : rx_bit;
    assign rx_word = {shreg[6:0], samp_val};
    assign ovf_now = done_now && is_slave && bf && !rd_buf;

    // Read views; bits 5..1 of status read zero in SPI use
    assign stat_rd = {input_sample_late, cke, 5'h00, bf};
    assign ctrl_rd = {write_collision_flag, ovf, en, clock_idle_polarity, mode};

    // ========================================================
    // Register read mux; the shift register is never visible
    always_comb begin
        rd_mux = 32'h0;
        if (wb_adr_i == ssp_pkg::ADR_BUF) begin
            rd_mux = {24'h0, xbuf};
        end else if (wb_adr_i == ssp_pkg::ADR_STAT) begin
            rd_mux = {24'h0, stat_rd};
        end else if (wb_adr_i == ssp_pkg::ADR_CTRL1) begin
            rd_mux = {24'h0, ctrl_rd};
        end
    end

    // Wishbone answer one cycle after the request; unmapped reads zero
    always_ff @(posedge clk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else if (ce) begin
            wb_ack_o <= bus_req;
            wb_dat_o <= (bus_req && !wb_we_i) ? rd_mux : 32'h0;
        end
    end

    // ========================================================
    // Software registers; every instance keeps its own copy
    always_ff @(posedge clk) begin
        if (srst) begin
            input_sample_late <= ssp_pkg::STAT_RST[ssp_pkg::ST_SMP];
            cke <= ssp_pkg::STAT_RST[ssp_pkg::ST_CKE];
        end else if (ce && wr_stat) begin
            input_sample_late <= wb_dat_i[ssp_pkg::ST_SMP];
            cke <= wb_dat_i[ssp_pkg::ST_CKE];
        end
    end

    // Control: hardware set of a flag wins over a software clear
    always_ff @(posedge clk) begin
        if (srst) begin
            write_collision_flag <= ssp_pkg::CTRL1_RST[ssp_pkg::C1_WRITE_COLLISION_FLAG];
            ovf <= ssp_pkg::CTRL1_RST[ssp_pkg::C1_OVF];
            en <= ssp_pkg::CTRL1_RST[ssp_pkg::C1_EN];
            clock_idle_polarity <= ssp_pkg::CTRL1_RST[ssp_pkg::C1_CKP];
            mode <= ssp_pkg::MODE_RST;
        end else if (ce) begin
            if (wr_ctrl) begin
                write_collision_flag <= wb_dat_i[ssp_pkg::C1_WRITE_COLLISION_FLAG];
                ovf <= wb_dat_i[ssp_pkg::C1_OVF];
                en <= wb_dat_i[ssp_pkg::C1_EN];
                clock_idle_polarity <= wb_dat_i[ssp_pkg::C1_CKP];
                mode <= wb_dat_i[3:0];
            end
            if (write_collision_flag_now) begin
                write_collision_flag <= 1'b1;
            end
            if (ovf_now) begin
                ovf <= 1'b1;
            end
        end
    end

    // Buffer full: set on a new word, cleared by reading the buffer
    always_ff @(posedge clk) begin
        if (srst) begin
            bf <= ssp_pkg::STAT_RST[ssp_pkg::ST_BF];
        end else if (ce) begin
            if (done_now) begin
                bf <= 1'b1;
            end else if (rd_buf) begin
                bf <= 1'b0;
            end
        end
    end

    // ========================================================
    // Buffer and shift register; overrun keeps the unread word
    always_ff @(posedge clk) begin
        if (srst) begin
            xbuf <= 8'h00;
            shreg <= 8'h00;
            rx_bit <= 1'b0;
        end else if (ce) begin
            if (buf_load) begin
                xbuf <= wb_dat_i[7:0];
                shreg <= wb_dat_i[7:0];
            end else begin
                if (shift_now) begin
                    shreg <= {shreg[6:0], samp_val};
                end
                if (done_now && !ovf_now) begin
                    xbuf <= rx_word;
                end
            end
            if (samp_now) begin
                rx_bit <= pin_s.sdi;
            end
        end
    end

    // ========================================================
    // Master sequencer; disabling stops it but keeps data and flags
    always_ff @(posedge clk) begin
        if (srst) begin
            mst_state <= ssp_pkg::MST_IDLE;
            tick <= 5'h00;
        end else if (ce) begin
            case (mst_state)
                ssp_pkg::MST_IDLE: begin
                    if (buf_load && en && is_master) begin
                        mst_state <= ssp_pkg::MST_RUN;
                        tick <= 5'h00;
                    end
                end
                ssp_pkg::MST_RUN: begin
                    if (abort) begin
                        mst_state <= ssp_pkg::MST_IDLE;
                    end else if (half_tick) begin
                        tick <= ntick;
                        if (last_t) begin
                            mst_state <= ssp_pkg::MST_IDLE;
                        end
                    end
                end
                default: mst_state <= ssp_pkg::MST_IDLE;
            endcase
        end
    end

    // Half period divider, restarted at each tick
    always_ff @(posedge clk) begin
        if (srst) begin
            hcnt <= 6'h00;
        end else if (ce) begin
            if (!run || half_tick) begin
                hcnt <= 6'h00;
            end else begin
                hcnt <= hcnt + 6'h01;
            end
        end
    end

    // Clock activity: exactly 16 toggles per word, idle otherwise
    always_ff @(posedge clk) begin
        if (srst) begin
            sck_act <= 1'b0;
        end else if (ce) begin
            if (!run || abort) begin
                sck_act <= 1'b0;
            end else if (half_tick && ntick <= ssp_pkg::EDGE_LAST) begin
                sck_act <= !sck_act;
            end
        end
    end

    // ========================================================
    // Slave bit counter; deselect drops a partial word
    always_ff @(posedge clk) begin
        if (srst) begin
            slv_cnt <= 3'h0;
            sck_q <= 1'b0;
        end else if (ce) begin
            sck_q <= pin_s.sck;
            if (!s_active) begin
                slv_cnt <= 3'h0;
            end else if (s_samp) begin
                slv_cnt <= slv_cnt + 3'h1;
            end
        end
    end

    // ========================================================
    // Pin drivers and port flag, all registered
    always_ff @(posedge clk) begin
        if (srst) begin
            sck_o <= 1'b0;
            sck_oe <= 1'b0;
            sdo_o <= 1'b0;
            sdo_oe <= 1'b0;
            port_irq_flag <= 1'b0;
        end else if (ce) begin
            sck_o <= clock_idle_polarity ^ sck_act;
            sck_oe <= en && is_master;
            sdo_o <= shreg[7];
            sdo_oe <= en && (is_master || (is_slave && selected));
            port_irq_flag <= done_now;
        end
    end

    // ========================================================
    // Checks
    logic [4:0] tgl_cnt;
    always_ff @(posedge clk) begin
        if (srst || (ce && buf_load)) begin
            tgl_cnt <= 5'h00;
        end else if (ce && m_step && ntick <= ssp_pkg::EDGE_LAST) begin
            tgl_cnt <= tgl_cnt + 5'h01;
        end
    end

    chk_edge_count:
    assert property (@(posedge clk) disable iff (srst)
        ce && m_step && last_t |=> tgl_cnt == 5'h10)
    else $error("master word did not give sixteen clock edges");

    chk_idle_level:
    assert property (@(posedge clk) disable iff (srst)
        ce && !run |=> sck_o == $past(clock_idle_polarity))
    else $error("serial clock not at idle level between words");

    chk_write_collision_flag_set:
    assert property (@(posedge clk) disable iff (srst)
        ce && write_collision_flag_now |=> write_collision_flag && (xbuf == $past(xbuf) || $past(done_now)))
    else $error("collision write not refused or flag not set");

    chk_load_both:
    assert property (@(posedge clk) disable iff (srst)
        ce && buf_load |=> xbuf == $past(wb_dat_i[7:0])
            && shreg == $past(wb_dat_i[7:0]))
    else $error("buffer write did not load both registers");

    chk_msb_first:
    assert property (@(posedge clk) disable iff (srst)
        ce && buf_load ##1 ce |=> sdo_o == $past(wb_dat_i[7], 2))
    else $error("first bit out is not the most significant");

    chk_word_done:
    assert property (@(posedge clk) disable iff (srst)
        ce && done_now && !ovf_now |=> bf && port_irq_flag
            && xbuf == $past(rx_word))
    else $error("received word not moved to buffer");

    chk_read_clear:
    assert property (@(posedge clk) disable iff (srst)
        ce && rd_buf && !done_now |=> !bf)
    else $error("buffer read did not clear full flag");

    chk_stat_write:
    assert property (@(posedge clk) disable iff (srst)
        ce && wr_stat && !done_now && !rd_buf |=>
            {input_sample_late, cke} == $past(wb_dat_i[7:6]) && bf == $past(bf))
    else $error("status write handled wrongly");

    chk_ctrl_write:
    assert property (@(posedge clk) disable iff (srst)
        ce && wr_ctrl |=> {en, clock_idle_polarity, mode} == $past(wb_dat_i[5:0]))
    else $error("control write not stored");

    chk_select_gate:
    assert property (@(posedge clk) disable iff (srst)
        ce && en && mode == ssp_pkg::MODE_SSEL && pin_s.ss_n
            |=> slv_cnt == 3'h0 && !sdo_oe)
    else $error("deselected slave still active");

    cov_master_word: cover property (@(posedge clk) m_step && last_t);
    cov_slave_word: cover property (@(posedge clk) s_samp && done_now);
    cov_collision: cover property (@(posedge clk) write_collision_flag_now);
    cov_overrun: cover property (@(posedge clk) ovf_now);

endmodule

// File: dv/ssp_spi_peer.sv
// Behavioural SPI peer: one byte each way on the shared clock line.
// Assumes sel_n frames each word and tx settles before sel_n falls.
`timescale 1ns/1ps

module ssp_spi_peer (
    input wire logic sck,
    input wire logic sel_n,
    input wire logic cpol,
    input wire logic cke,
    input wire logic mosi,
    input wire logic [7:0] tx,
    output logic miso,
    output logic [7:0] rx
);
    logic [7:0] sh;
    int nb;
    // ==================================================
    // Framing
    // First bit shows as soon as we are selected
    initial miso = 1'b0;
    always @(negedge sel_n) begin
        sh = tx;
        nb = 0;
        miso = tx[7];
    end
    // Released line flips, so a stale level never looks valid
    always @(posedge sel_n) miso = ~miso;
    // Sample on one edge, shift out on the other after a sample
    always @(sck) begin
        if (!sel_n && ((sck ^ cpol) == cke)) begin
            rx = {rx[6:0], mosi};
            nb++;
        end else if (!sel_n && nb > 0 && nb < 8) begin
            sh = sh << 1;
            miso = sh[7];
        end
    end
endmodule

// File: dv/ssp_spi_port_bench.sv
// Self-checking bench: registers, master and slave words of the port.
// Assumes the peer model; one 20 MHz domain, bench drives slave clock.
`timescale 1ns/1ps

module ssp_spi_port_bench;
    logic clk = 0, srst = 1, cyc = 0, we = 0, tick = 0;
    logic bsck = 0, ss_n = 1, pol = 0, ckeb = 0, miso;
    logic [7:0] adr = 8'h00, wd = 8'h00, q, ptx = 8'h00, prx, st, m, tx;
    logic [3:0] sel = 4'h1;
    logic [31:0] dat_o;
    logic ack, sck_o, sck_oe, sdo_o, sdo_oe, irq;
    logic [2:0] tcnt = 3'h0;
    int n_fail = 0, n_compared = 0, n_irq = 0, i0, k;
    wire sck_line = sck_oe ? sck_o : bsck;
    wire mosi = sdo_oe ? sdo_o : ~sdo_o;

    // ==================================================
    // Clock, timer pulse and word counter
    always #25 clk = ~clk;
    // Timer pulse every six cycles keeps mode 0011 slow enough to sample
    always @(posedge clk) begin
        tcnt <= (tcnt == 3'h5) ? 3'h0 : tcnt + 3'h1;
        tick <= (tcnt == 3'h0);
        if (irq === 1'b1) n_irq <= n_irq + 1;
    end

    ssp_spi_port u_dut (
        .clk(clk),
        .srst(srst),
        .ce(1'b1),
        .wb_cyc_i(cyc),
        .wb_stb_i(cyc),
        .wb_we_i(we),
        .wb_adr_i(adr),
        .wb_sel_i(sel),
        .wb_dat_i({24'h000000, wd}),
        .wb_dat_o(dat_o),
        .wb_ack_o(ack),
        .timer_tick(tick),
        .sck_i(sck_line),
        .sck_o(sck_o),
        .sck_oe(sck_oe),
        .sdo_o(sdo_o),
        .sdo_oe(sdo_oe),
        .sdi_i(miso),
        .ss_n_i(ss_n),
        .port_irq_flag(irq)
    );

    ssp_spi_peer u_peer (
        .sck(sck_line),
        .sel_n(ss_n),
        .cpol(pol),
        .cke(ckeb),
        .mosi(mosi),
        .tx(ptx),
        .miso(miso),
        .rx(prx)
    );

    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        n_compared++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch at %0t: saw %h want %h", $time, s, e);
        end
    endtask

    task automatic end_sim;
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // One classic cycle; held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = dat_o[7:0];
        cyc <= 1'b0;
        if (ack !== 1'b1) begin
            n_fail++;
            end_sim();
        end
    endtask

    task automatic wait_irq(input int base);
        int n;
        for (n = 0; n < 4000 && n_irq == base; n++) @(posedge clk);
        if (n_irq == base) begin
            n_fail++;
            end_sim();
        end
    endtask

    // Disable, set up, then enable, as software is meant to
    task automatic cfg(input logic [7:0] s, input logic [7:0] c);
        wb(1'b1, ssp_pkg::ADR_CTRL1, 8'h00);
        bsck <= c[4];
        pol <= c[4];
        ckeb <= s[6];
        wb(1'b1, ssp_pkg::ADR_STAT, s);
        wb(1'b1, ssp_pkg::ADR_CTRL1, c & 8'hdf);
        wb(1'b1, ssp_pkg::ADR_CTRL1, c);
    endtask

    task automatic arm(input logic [7:0] t);
        ss_n <= 1'b1;
        ptx <= t;
        @(posedge clk);
        ss_n <= 1'b0;
        @(posedge clk);
    endtask

    // Sixteen edges at 400 ns a period, then back at idle
    task automatic slv_clk;
        repeat (16) begin
            repeat (4) @(posedge clk);
            bsck <= ~bsck;
        end
        repeat (6) @(posedge clk);
    endtask

    initial begin
        i0 = $urandom(36306);
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        wb(1'b0, ssp_pkg::ADR_STAT, 8'h00);
        chk(q, ssp_pkg::STAT_RST);
        wb(1'b0, ssp_pkg::ADR_CTRL1, 8'h00);
        chk(q, ssp_pkg::CTRL1_RST);
        wb(1'b0, 8'h0c, 8'h00);
        chk(q, 8'h00);
        wb(1'b1, ssp_pkg::ADR_STAT, 8'hff);
        wb(1'b0, ssp_pkg::ADR_STAT, 8'h00);
        chk(q, 8'hc0);
        m = $urandom & 8'hdf;
        wb(1'b1, ssp_pkg::ADR_CTRL1, m);
        wb(1'b0, ssp_pkg::ADR_CTRL1, 8'h00);
        chk(q, m);
        wb(1'b1, ssp_pkg::ADR_CTRL1, 8'h00);
        tx = $urandom;
        wb(1'b1, ssp_pkg::ADR_BUF, tx);
        wb(1'b0, ssp_pkg::ADR_BUF, 8'h00);
        chk(q, tx);
        $display("test registers done");
        // Master: every rate and every clock polarity and edge
        for (k = 0; k < 16; k++) begin
            st = {1'($urandom), k[0], 6'h00};
            m = {3'b001, k[1], 2'b00, k[3:2]};
            cfg(st, m);
            tx = $urandom;
            arm($urandom);
            i0 = n_irq;
            wb(1'b1, ssp_pkg::ADR_BUF, tx);
            if (k == 5) begin
                wb(1'b1, ssp_pkg::ADR_BUF, ~tx);
                wb(1'b0, ssp_pkg::ADR_CTRL1, 8'h00);
                chk(q, m | 8'h80);
            end
            wait_irq(i0);
            repeat (2) @(posedge clk);
            chk({7'h00, sck_o}, {7'h00, k[1]});
            chk(prx, tx);
            chk({7'h00, sck_oe}, 8'h01);
            wb(1'b0, ssp_pkg::ADR_STAT, 8'h00);
            chk(q, st | 8'h01);
            wb(1'b0, ssp_pkg::ADR_BUF, 8'h00);
            // At /4 the pin synchroniser lag blurs the input sample
            if (k[3:2] != 2'b00) chk(q, ptx);
            wb(1'b0, ssp_pkg::ADR_STAT, 8'h00);
            chk(q, st);
        end
        $display("test master done");
        // Slave: bench is the clock source, select used and ignored
        for (k = 0; k < 4; k++) begin
            m = {3'b001, k[1], 3'h2, k[0]};
            cfg({1'b0, k[0] ^ k[1], 6'h00}, m);
            tx = $urandom;
            arm($urandom);
            st = ptx;
            wb(1'b1, ssp_pkg::ADR_BUF, tx);
            i0 = n_irq;
            slv_clk();
            wait_irq(i0);
            chk(prx, tx);
            chk({7'h00, sck_oe}, 8'h00);
            if (k == 3) begin
                arm($urandom);
                slv_clk();
                wb(1'b0, ssp_pkg::ADR_CTRL1, 8'h00);
                chk(q, m | 8'h40);
            end
            wb(1'b0, ssp_pkg::ADR_BUF, 8'h00);
            // Overrun keeps the first word; st holds what the peer sent
            chk(q, st);
            if (k == 2) begin
                ss_n <= 1'b1;
                i0 = n_irq;
                slv_clk();
                chk(8'(n_irq), 8'(i0));
            end
        end
        $display("test slave done");
        end_sim();
    end
endmodule
